//--- rtl/iepb_consts.svh
`ifndef IEPB_CONSTS_SVH
`define IEPB_CONSTS_SVH

// special function register addresses
`define IEPB_ADDR_IE_FIRST   8'hA8
`define IEPB_ADDR_IE_SECOND  8'hA9
`define IEPB_ADDR_IE_THIRD   8'hAA
`define IEPB_ADDR_IP_FIRST   8'hB8
`define IEPB_ADDR_IP_SECOND  8'hB9

// implemented bits of each register, reserved bits masked off
`define IEPB_MASK_IE_FIRST   8'h83
`define IEPB_MASK_IE_SECOND  8'hEF
`define IEPB_MASK_IE_THIRD   8'h1F
`define IEPB_MASK_IP_FIRST   8'h7F
`define IEPB_MASK_IP_SECOND  8'hEF
`define IEPB_RESET_VALUE     8'h00
`define IEPB_UNMAPPED_READ   8'h00

// field positions, first enable register
`define IEPB_BIT_GLOBAL      7
`define IEPB_BIT_T0_EN       1
`define IEPB_BIT_EXT0_EN     0
// field positions, first priority register
`define IEPB_BIT_ADC_PRI     6
`define IEPB_BIT_T2_PRI      5
`define IEPB_BIT_UART_PRI    4
`define IEPB_BIT_T1_PRI      3
`define IEPB_BIT_EXT1_PRI    2
`define IEPB_BIT_T0_PRI      1
`define IEPB_BIT_EXT0_PRI    0
// field positions, second enable and second priority registers
`define IEPB_BIT_T4          7
`define IEPB_BIT_T3          6
`define IEPB_BIT_CMP         5
`define IEPB_BIT_EXT2        3
`define IEPB_BIT_BTM         2
`define IEPB_BIT_PWM         1
`define IEPB_BIT_PORT0       0
// field positions, third enable register: ports 1..5 at bits 0..4
`define IEPB_BIT_PORT1       0

// source index equals the query number; smaller is served first within a priority level
`define IEPB_SRC_COUNT       20
`define IEPB_SRC_EXT0        0
`define IEPB_SRC_T0          1
`define IEPB_SRC_EXT1        2
`define IEPB_SRC_T1          3
`define IEPB_SRC_UART        4
`define IEPB_SRC_T2          5
`define IEPB_SRC_ADC         6
`define IEPB_SRC_PORT0       7
`define IEPB_SRC_PWM         8
`define IEPB_SRC_BTM         9
`define IEPB_SRC_EXT2        10
`define IEPB_SRC_SPARE       11
`define IEPB_SRC_CMP         12
`define IEPB_SRC_T3          13
`define IEPB_SRC_T4          14
`define IEPB_SRC_PORT1       15
`define IEPB_PORT_UPPER      5

`endif

//--- rtl/iepb_pkg.sv
package iepb_pkg;

  typedef logic [19:0] iepb_src_t;
  typedef logic [4:0]  iepb_idx_t;
  typedef logic [7:0]  iepb_byte_t;

  // nesting of service routines in progress
  typedef enum logic [1:0] {
    IEPB_IDLE,
    IEPB_LOW,
    IEPB_HIGH,
    IEPB_LOW_HIGH
  } iepb_level_e;

endpackage

//--- rtl/iepb_arb_if.sv
`timescale 1ns/1ps

interface iepb_arb_if;
  import iepb_pkg::*;

  iepb_src_t pending;
  iepb_src_t prio;
  logic      allow_low;
  logic      allow_high;
  logic      win_valid;
  iepb_idx_t win_idx;
  logic      win_high;

  modport bank (
    output pending,
    output prio,
    output allow_low,
    output allow_high,
    input  win_valid,
    input  win_idx,
    input  win_high
  );

  modport arb (
    input  pending,
    input  prio,
    input  allow_low,
    input  allow_high,
    output win_valid,
    output win_idx,
    output win_high
  );

endinterface

//--- rtl/iepb_arbiter.sv
`timescale 1ns/1ps
`include "iepb_consts.svh"

module iepb_arbiter
  import iepb_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_en,
  iepb_arb_if.arb   arb
);

  iepb_src_t hi_set;
  iepb_src_t lo_set;
  logic      nxt_valid;
  logic      nxt_high;
  iepb_idx_t nxt_idx;
  logic      win_valid_ff;
  logic      win_high_ff;
  iepb_idx_t win_idx_ff;

  // lowest set index wins
  function automatic iepb_idx_t first_set(input iepb_src_t v);
    iepb_idx_t r;
    r = '0;
    for (int i = `IEPB_SRC_COUNT - 1; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    hi_set    = arb.pending & arb.prio;
    lo_set    = arb.pending & ~arb.prio;
    nxt_valid = 1'b0;
    nxt_high  = 1'b0;
    nxt_idx   = '0;
    // high level always beats low, even with a larger query number
    if (arb.allow_high && (hi_set != '0))
    begin
      nxt_valid = 1'b1;
      nxt_high  = 1'b1;
      nxt_idx   = first_set(hi_set);
    end
    else if (arb.allow_low && (lo_set != '0))
    begin
      nxt_valid = 1'b1;
      nxt_idx   = first_set(lo_set);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      win_valid_ff <= 1'b0;
      win_high_ff  <= 1'b0;
      win_idx_ff   <= '0;
    end
    else if (clock_en)
    begin
      win_valid_ff <= nxt_valid;
      win_high_ff  <= nxt_high;
      win_idx_ff   <= nxt_idx;
    end
  end

  assign arb.win_valid = win_valid_ff;
  assign arb.win_high  = win_high_ff;
  assign arb.win_idx   = win_idx_ff;

endmodule

//--- rtl/iepb_bank.sv
`timescale 1ns/1ps
`include "iepb_consts.svh"


module iepb_bank
  import iepb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clock_en,
  input  wire iepb_byte_t sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire iepb_byte_t sfr_wdata,
  output logic [7:0]      sfr_rdata,
  input  wire iepb_src_t  irq_flag,
  input  wire logic       irq_ack,
  input  wire logic       irq_reti,
  output logic            irq_req,
  output logic [4:0]      irq_vector,
  output logic            irq_high,
  output logic [19:0]     irq_active,
  output logic [1:0]      service_level
);

  iepb_byte_t  ie_first_ff;
  iepb_byte_t  ie_second_ff;
  iepb_byte_t  ie_third_ff;
  iepb_byte_t  ip_first_ff;
  iepb_byte_t  ip_second_ff;
  iepb_byte_t  sfr_rdata_ff;
  iepb_byte_t  nxt_rdata;
  iepb_src_t   src_enable;
  iepb_src_t   src_prio;
  iepb_src_t   src_active;
  iepb_src_t   irq_active_ff;
  logic        global_irq_enable;
  logic        ack_taken;
  logic        nxt_req;
  logic        irq_req_ff;
  logic        irq_high_ff;
  iepb_idx_t   irq_vector_ff;
  iepb_level_e level_ff;
  iepb_level_e nxt_level;
  logic        allow_low;
  logic        allow_high;

  iepb_arb_if arb_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // register writes, one bank each; reserved positions never store a one
  always_ff @(posedge clock)
  begin
    if (reset)
      ie_first_ff <= `IEPB_RESET_VALUE;
    else if (clock_en && sfr_wr && (sfr_addr == `IEPB_ADDR_IE_FIRST))
      ie_first_ff <= sfr_wdata & `IEPB_MASK_IE_FIRST;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ie_second_ff <= `IEPB_RESET_VALUE;
    else if (clock_en && sfr_wr && (sfr_addr == `IEPB_ADDR_IE_SECOND))
      ie_second_ff <= sfr_wdata & `IEPB_MASK_IE_SECOND;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ie_third_ff <= `IEPB_RESET_VALUE;
    else if (clock_en && sfr_wr && (sfr_addr == `IEPB_ADDR_IE_THIRD))
      ie_third_ff <= sfr_wdata & `IEPB_MASK_IE_THIRD;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ip_first_ff <= `IEPB_RESET_VALUE;
    else if (clock_en && sfr_wr && (sfr_addr == `IEPB_ADDR_IP_FIRST))
      ip_first_ff <= sfr_wdata & `IEPB_MASK_IP_FIRST;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ip_second_ff <= `IEPB_RESET_VALUE;
    else if (clock_en && sfr_wr && (sfr_addr == `IEPB_ADDR_IP_SECOND))
      ip_second_ff <= sfr_wdata & `IEPB_MASK_IP_SECOND;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads; unmapped addresses answer zero
  always_comb
  begin
    nxt_rdata = `IEPB_UNMAPPED_READ;
    unique case (sfr_addr)
      `IEPB_ADDR_IE_FIRST:  nxt_rdata = ie_first_ff;
      `IEPB_ADDR_IE_SECOND: nxt_rdata = ie_second_ff;
      `IEPB_ADDR_IE_THIRD:  nxt_rdata = ie_third_ff;
      `IEPB_ADDR_IP_FIRST:  nxt_rdata = ip_first_ff;
      `IEPB_ADDR_IP_SECOND: nxt_rdata = ip_second_ff;
      default:              nxt_rdata = `IEPB_UNMAPPED_READ;
    endcase
  end

  // held until the next read strobe, so a slow core may sample late
  always_ff @(posedge clock)
  begin
    if (reset)
      sfr_rdata_ff <= `IEPB_UNMAPPED_READ;
    else if (clock_en && sfr_rd)
      sfr_rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-source enable and priority map, indexed by query number
  assign global_irq_enable = ie_first_ff[`IEPB_BIT_GLOBAL];

  always_comb
  begin
    src_enable = '0;
    src_enable[`IEPB_SRC_T0]    = ie_first_ff[`IEPB_BIT_T0_EN];
    src_enable[`IEPB_SRC_EXT0]  = ie_first_ff[`IEPB_BIT_EXT0_EN];
    src_enable[`IEPB_SRC_T4]    = ie_second_ff[`IEPB_BIT_T4];
    src_enable[`IEPB_SRC_T3]    = ie_second_ff[`IEPB_BIT_T3];
    src_enable[`IEPB_SRC_CMP]   = ie_second_ff[`IEPB_BIT_CMP];
    src_enable[`IEPB_SRC_EXT2]  = ie_second_ff[`IEPB_BIT_EXT2];
    src_enable[`IEPB_SRC_BTM]   = ie_second_ff[`IEPB_BIT_BTM];
    src_enable[`IEPB_SRC_PWM]   = ie_second_ff[`IEPB_BIT_PWM];
    src_enable[`IEPB_SRC_PORT0] = ie_second_ff[`IEPB_BIT_PORT0];
    // ports 1..5 have enables here; they have no priority bit, so always low
    for (int p = 0; p < `IEPB_PORT_UPPER; p++)
    begin
      src_enable[`IEPB_SRC_PORT1 + p] = ie_third_ff[`IEPB_BIT_PORT1 + p];
    end
  end

  always_comb
  begin
    src_prio   = '0;
    src_prio[`IEPB_SRC_ADC]     = ip_first_ff[`IEPB_BIT_ADC_PRI];
    src_prio[`IEPB_SRC_T2]      = ip_first_ff[`IEPB_BIT_T2_PRI];
    src_prio[`IEPB_SRC_UART]    = ip_first_ff[`IEPB_BIT_UART_PRI];
    src_prio[`IEPB_SRC_T1]      = ip_first_ff[`IEPB_BIT_T1_PRI];
    src_prio[`IEPB_SRC_EXT1]    = ip_first_ff[`IEPB_BIT_EXT1_PRI];
    src_prio[`IEPB_SRC_T0]      = ip_first_ff[`IEPB_BIT_T0_PRI];
    src_prio[`IEPB_SRC_EXT0]    = ip_first_ff[`IEPB_BIT_EXT0_PRI];
    src_prio[`IEPB_SRC_T4]      = ip_second_ff[`IEPB_BIT_T4];
    src_prio[`IEPB_SRC_T3]      = ip_second_ff[`IEPB_BIT_T3];
    src_prio[`IEPB_SRC_CMP]     = ip_second_ff[`IEPB_BIT_CMP];
    src_prio[`IEPB_SRC_EXT2]    = ip_second_ff[`IEPB_BIT_EXT2];
    src_prio[`IEPB_SRC_BTM]     = ip_second_ff[`IEPB_BIT_BTM];
    src_prio[`IEPB_SRC_PWM]     = ip_second_ff[`IEPB_BIT_PWM];
    src_prio[`IEPB_SRC_PORT0]   = ip_second_ff[`IEPB_BIT_PORT0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gating per source: flag, own enable and global enable all needed
  genvar g;
  generate
    for (g = 0; g < `IEPB_SRC_COUNT; g++)
    begin : gate
      assign src_active[g] = irq_flag[g] & src_enable[g]
                           & global_irq_enable;
    end
  endgenerate

  // registered so the core sees a glitch-free source map
  always_ff @(posedge clock)
  begin
    if (reset)
      irq_active_ff <= '0;
    else if (clock_en)
      irq_active_ff <= src_active;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nesting tracker: at most one low and one high routine in flight
  assign ack_taken = irq_ack & irq_req_ff;

  always_comb
  begin
    nxt_level = level_ff;
    unique case (level_ff)
      IEPB_IDLE:
      begin
        if (ack_taken)
          nxt_level = irq_high_ff ? IEPB_HIGH : IEPB_LOW;
      end
      IEPB_LOW:
      begin
        // a high ack wins over a return in the same cycle
        if (ack_taken && irq_high_ff)
          nxt_level = IEPB_LOW_HIGH;
        else if (irq_reti)
          nxt_level = IEPB_IDLE;
      end
      IEPB_HIGH:
      begin
        if (irq_reti)
          nxt_level = IEPB_IDLE;
      end
      IEPB_LOW_HIGH:
      begin
        if (irq_reti)
          nxt_level = IEPB_LOW;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      level_ff <= IEPB_IDLE;
    else if (clock_en)
      level_ff <= nxt_level;
  end

  // same level never nests: low waits for idle, high waits for no high
  assign arb_bus.pending    = src_active;
  assign arb_bus.prio       = src_prio;
  assign allow_low          = (level_ff == IEPB_IDLE);
  assign allow_high         = (level_ff == IEPB_IDLE) || (level_ff == IEPB_LOW);
  assign arb_bus.allow_low  = allow_low;
  assign arb_bus.allow_high = allow_high;

  // a cycle of arbitration latency traded for a short path from the flags
  iepb_arbiter u_arbiter (
    .clock    (clock),
    .reset    (reset),
    .clock_en (clock_en),
    .arb      (arb_bus.arb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // request to the core; winner re-checked against the current level because
  // the arbiter result is one cycle old
  always_comb
  begin
    nxt_req = 1'b0;
    if (arb_bus.win_valid && !ack_taken)
    begin
      if (arb_bus.win_high)
        nxt_req = allow_high;
      else
        nxt_req = allow_low;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_req_ff <= 1'b0;
    else if (clock_en)
      irq_req_ff <= nxt_req;
  end

  // level and vector follow the winner even with no request; the core ignores them
  always_ff @(posedge clock)
  begin
    if (reset)
      irq_high_ff <= 1'b0;
    else if (clock_en)
      irq_high_ff <= arb_bus.win_high;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_vector_ff <= '0;
    else if (clock_en)
      irq_vector_ff <= arb_bus.win_idx;
  end

  assign sfr_rdata     = sfr_rdata_ff;
  assign irq_req       = irq_req_ff;
  assign irq_high      = irq_high_ff;
  assign irq_vector    = irq_vector_ff;
  assign irq_active    = irq_active_ff;
  assign service_level = level_ff;

endmodule

//--- testbench/iepb_bank_chk.sv
`timescale 1ns/1ps
module iepb_bank_chk
  import iepb_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clock_en,
  input wire iepb_byte_t  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire iepb_src_t   irq_flag,
  input wire logic        irq_ack,
  input wire logic        irq_reti,
  input wire logic        irq_req,
  input wire logic        irq_high,
  input wire logic [19:0] irq_active,
  input wire logic [1:0]  service_level
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_unmapped_zero: assert property (
    sfr_rd && clock_en && !(sfr_addr inside {8'hA8, 8'hA9, 8'hAA, 8'hB8, 8'hB9})
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_reserved_mid: assert property (
    sfr_rd && clock_en && sfr_addr inside {8'hA9, 8'hB9} |=> !sfr_rdata[4])
    else $error("reserved bit 4 reads one");
  a_reserved_top: assert property (
    sfr_rd && clock_en && sfr_addr == 8'hAA |=> sfr_rdata[7:5] == 3'h0)
    else $error("reserved top bits read nonzero");
  a_reserved_adc: assert property (
    sfr_rd && clock_en && sfr_addr == 8'hB8 |=> !sfr_rdata[7])
    else $error("reserved priority bit reads one");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_active_cause: assert property (
    clock_en |=> (irq_active & ~$past(irq_flag)) == 20'h00000)
    else $error("active source without flag");
  a_req_cause: assert property (irq_req |-> $past(irq_active) != 20'h00000)
    else $error("request without active source");
  a_nest_block: assert property (
    irq_req && service_level != IEPB_IDLE |-> irq_high && service_level == IEPB_LOW)
    else $error("request not allowed at this nesting");
  a_ack_low: assert property (
    irq_req && irq_ack && !irq_high && service_level == IEPB_IDLE && clock_en
    |=> service_level == IEPB_LOW && !irq_req) else $error("low ack misfiled");
  a_ack_high: assert property (
    irq_req && irq_ack && irq_high && service_level == IEPB_LOW && clock_en
    |=> service_level == IEPB_LOW_HIGH) else $error("high ack misfiled");
  a_reti_nest: assert property (
    service_level == IEPB_LOW_HIGH && irq_reti && !irq_ack && clock_en
    |=> service_level == IEPB_LOW) else $error("return from high misfiled");
  a_reti_idle: assert property (
    service_level == IEPB_IDLE && irq_reti && !irq_ack && clock_en
    |=> service_level == IEPB_IDLE) else $error("return in idle changed state");
  // frozen clock must not leak into state
  a_freeze: assert property (!clock_en |=>
    $stable(sfr_rdata) && $stable(irq_req) && $stable(service_level))
    else $error("state moved while frozen");
endmodule
////////////////////////////////////////
bind iepb_bank iepb_bank_chk u_chk (
  .clock         (clock),
  .reset         (reset),
  .clock_en      (clock_en),
  .sfr_addr      (sfr_addr),
  .sfr_rd        (sfr_rd),
  .sfr_rdata     (sfr_rdata),
  .irq_flag      (irq_flag),
  .irq_ack       (irq_ack),
  .irq_reti      (irq_reti),
  .irq_req       (irq_req),
  .irq_high      (irq_high),
  .irq_active    (irq_active),
  .service_level (service_level)
);

//--- testbench/iepb_core_model.sv
`timescale 1ns/1ps
module iepb_core_model
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic       take,
  input  wire logic       ret_go,
  output logic            irq_ack,
  output logic            irq_reti
);
  logic [3:0] wait_ff;
  // ack only while a request shows; delay mimics a slow core
  always_ff @(posedge clock)
  begin
    if (reset || !irq_req || irq_ack)
    begin
      irq_ack <= 1'b0;
      wait_ff <= 4'h0;
    end
    else if (take && wait_ff >= ack_delay)
      irq_ack <= 1'b1;
    else
      wait_ff <= wait_ff + 4'h1;
  end
  always_ff @(posedge clock)
  begin
    irq_reti <= ret_go && !reset;
  end
endmodule

//--- testbench/tb_interrupt_enable_priority_bank.sv
`timescale 1ns/1ps
module tb_interrupt_enable_priority_bank
  import iepb_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        clock_en = 1'b1;
  iepb_byte_t  sfr_addr = 8'h00;
  iepb_byte_t  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  iepb_src_t   irq_flag = 20'h00000;
  logic [3:0]  ack_delay = 4'h0;
  logic        take = 1'b0;
  logic        ret_go = 1'b0;
  logic        irq_ack;
  logic        irq_reti;
  logic        irq_req;
  logic        irq_high;
  logic [7:0]  sfr_rdata;
  logic [4:0]  irq_vector;
  logic [19:0] irq_active;
  logic [1:0]  service_level;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [4:0]  srcs [14] = '{5'h00, 5'h01, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0C,
                             5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13};
  logic [2:0]  bits [14] = '{0, 1, 0, 1, 2, 3, 5, 6, 7, 0, 1, 2, 3, 4};
  logic [7:0]  ra [5] = '{8'hA8, 8'hA9, 8'hAA, 8'hB8, 8'hB9};
  logic [7:0]  rm [5] = '{8'h83, 8'hEF, 8'h1F, 8'h7F, 8'hEF};

  always #50 clock = ~clock;

  iepb_bank DUT (.clock(clock), .reset(reset), .clock_en(clock_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .irq_flag(irq_flag), .irq_ack(irq_ack), .irq_reti(irq_reti), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_high(irq_high), .irq_active(irq_active),
    .service_level(service_level));
  iepb_core_model u_core (.clock(clock), .reset(reset), .irq_req(irq_req),
    .ack_delay(ack_delay), .take(take), .ret_go(ret_go), .irq_ack(irq_ack),
    .irq_reti(irq_reti));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    ticks(0);
    chk("sfr_rdata", 20'(sfr_rdata), 20'(exp));
  endtask
  task automatic ret();
    @(posedge clock);
    ret_go <= 1'b1;
    @(posedge clock);
    ret_go <= 1'b0;
  endtask
  // bounded wait; a miss ends the run
  task automatic wait_lvl(input logic [1:0] want);
    repeat (20) if (service_level !== want) @(negedge clock);
    chk("service_level", 20'(service_level), 20'(want));
    if (service_level !== want)
      wrap_up();
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [7:0] a;
    logic [7:0] m;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], 8'h00);
      wr(ra[i], 8'hFF);
      rd(ra[i], rm[i]);
    end
    wr(8'hA7, 8'hFF);
    rd(8'hA7, 8'h00);
    @(posedge clock);
    clock_en <= 1'b0;
    wr(8'hA9, 8'h00);
    @(posedge clock);
    clock_en <= 1'b1;
    rd(8'hA9, 8'hEF);
    for (int i = 0; i < 5; i++)
      wr(ra[i], 8'h00);
    $display("test registers done");
    for (int i = 0; i < 14; i++)
    begin
      a = (i < 2) ? 8'hA8 : (i < 9) ? 8'hA9 : 8'hAA;
      m = 8'h01 << bits[i];
      @(posedge clock);
      irq_flag <= 20'h00001 << srcs[i];
      wr(8'hA8, 8'h80);
      ticks(3);
      chk("irq_active", irq_active, 20'h00000);
      wr(a, (a == 8'hA8) ? (m | 8'h80) : m);
      ticks(3);
      chk("irq_active", irq_active, 20'h00001 << srcs[i]);
      chk("irq_vector", 20'(irq_vector), 20'(srcs[i]));
      chk("irq_high", 20'(irq_high), 20'h00000);
      if (i < 9)
      begin
        wr(a + 8'h10, m);
        ticks(3);
        chk("irq_high", 20'(irq_high), 20'h00001);
        wr(a + 8'h10, 8'h00);
      end
      wr(8'hA8, (a == 8'hA8) ? m : 8'h00);
      ticks(3);
      chk("irq_req", {irq_active[18:0], irq_req}, 20'h00000);
      wr(a, 8'h00);
    end
    $display("test sources done");
    // t4 and ext2 pending together, both low
    @(posedge clock);
    irq_flag <= 20'h04400;
    wr(8'hA9, 8'h88);
    wr(8'hA8, 8'h80);
    ticks(3);
    chk("irq_vector", 20'(irq_vector), 20'h0000A);
    @(posedge clock);
    ack_delay <= 4'h3;
    take <= 1'b1;
    wait_lvl(2'h1);
    @(posedge clock);
    take <= 1'b0;
    ticks(2);
    chk("irq_req", 20'(irq_req), 20'h00000);
    wr(8'hB9, 8'h80);
    ticks(3);
    chk("irq_vector", 20'(irq_vector), 20'h0000E);
    chk("irq_high", 20'(irq_high), 20'h00001);
    @(posedge clock);
    ack_delay <= 4'h0;
    take <= 1'b1;
    wait_lvl(2'h3);
    @(posedge clock);
    take <= 1'b0;
    irq_flag <= 20'h00400;
    ret();
    wait_lvl(2'h1);
    ticks(3);
    chk("irq_req", 20'(irq_req), 20'h00000);
    @(posedge clock);
    irq_flag <= 20'h00000;
    ret();
    wait_lvl(2'h0);
    ret();
    ticks(3);
    chk("service_level", 20'(service_level), 20'h00000);
    $display("test nesting done");
    wrap_up();
  end
endmodule
